/* File: common/ebpwm_pkg.sv */
// Purpose: Shared constants and types of the enhanced bridge PWM output stage
// Assumes: i_clk_sys is the oscillator clock, so one oscillator period is one cycle
// Notes:   Register map is an 8-bit wide, eight-entry plain-port map

package ebpwm_pkg;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  localparam int EBPWM_AW = 3;
  localparam int EBPWM_DW = 8;

  localparam logic [2:0] EBPWM_OFS_CTRL = 3'h0;
  localparam logic [2:0] EBPWM_OFS_DBAND = 3'h1;
  localparam logic [2:0] EBPWM_OFS_PERIOD = 3'h2;
  localparam logic [2:0] EBPWM_OFS_DUTY = 3'h3;
  localparam logic [2:0] EBPWM_OFS_TCTRL = 3'h4;
  localparam logic [2:0] EBPWM_OFS_STEER = 3'h5;
  localparam logic [2:0] EBPWM_OFS_STATUS = 3'h6;
  localparam logic [2:0] EBPWM_OFS_TIMER = 3'h7;

  // Control register fields
  localparam int EBPWM_CFG_MSB = 7;
  localparam int EBPWM_CFG_LSB = 6;
  localparam int EBPWM_DLO_MSB = 5;
  localparam int EBPWM_DLO_LSB = 4;
  localparam int EBPWM_MSEL_MSB = 3;
  localparam int EBPWM_MSEL_LSB = 0;
  localparam logic [1:0] EBPWM_MSEL_PWM = 2'h3;
  localparam int EBPWM_POL_AC_BIT = 1;
  localparam int EBPWM_POL_BD_BIT = 0;

  // Timer control fields
  localparam int EBPWM_TON_BIT = 2;
  localparam int EBPWM_PRE_MSB = 1;

  // Status fields
  localparam int EBPWM_ST_RUN_BIT = 4;
  localparam int EBPWM_ST_DIR_BIT = 5;
  localparam int EBPWM_ST_HOLD_BIT = 6;

  // Reset values
  localparam logic [7:0] EBPWM_RST_CTRL = 8'h00;
  localparam logic [7:0] EBPWM_RST_DBAND = 8'h00;
  localparam logic [7:0] EBPWM_RST_PERIOD = 8'hFF;
  localparam logic [7:0] EBPWM_RST_DUTY = 8'h00;
  localparam logic [7:0] EBPWM_RST_TCTRL = 8'h00;
  localparam logic [3:0] EBPWM_RST_STEER = 4'h1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int EBPWM_CLK_PERIOD_NS = 50;
  localparam int EBPWM_TOSC_NS = 50;
  localparam int EBPWM_DB_TOSC_PER_COUNT = 4;
  // Least time, rounded up to whole cycles
  localparam int EBPWM_DB_CYC_PER_COUNT =
    (EBPWM_DB_TOSC_PER_COUNT * EBPWM_TOSC_NS + EBPWM_CLK_PERIOD_NS - 1) / EBPWM_CLK_PERIOD_NS;
  localparam logic [3:0] EBPWM_PRE1_LIM = 4'h0;
  localparam logic [3:0] EBPWM_PRE4_LIM = 4'h3;
  localparam logic [3:0] EBPWM_PRE16_LIM = 4'hF;
  localparam logic [1:0] EBPWM_QPHASE_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EBPWM_CFG_SINGLE = 2'b00,
    EBPWM_CFG_FWD = 2'b01,
    EBPWM_CFG_HALF = 2'b10,
    EBPWM_CFG_REV = 2'b11
  } ebpwm_cfg_e;

  typedef enum logic [1:0] {
    EBPWM_ST_OFF = 2'b00,
    EBPWM_ST_ARMED = 2'b01,
    EBPWM_ST_RUN = 2'b10
  } ebpwm_state_e;

endpackage

/* File: rtl/ebpwm_timebase.sv */
// Purpose: Period time base with prescaler and quarter-phase fine count
// Assumes: One clock, i_clk_sys at the oscillator rate
// Notes:   o_fine is the ten-bit position {timer, phase}; o_wrap marks the first cycle of fine == 0 after a period wrap

`timescale 1ns/100ps

module ebpwm_timebase
  import ebpwm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [1:0] i_pre_sel,
  input wire logic [7:0] i_period,
  output logic [7:0] o_timer,
  output logic [9:0] o_fine,
  output logic o_wrap
);

  logic [3:0] pre_cnt_q;
  logic [3:0] pre_lim;
  logic [1:0] phase_q;
  logic [7:0] tmr_q;
  logic wrap_q;
  logic step;
  logic tick;

  always_comb begin
    if (i_pre_sel[EBPWM_PRE_MSB]) begin
      pre_lim = EBPWM_PRE16_LIM;
    end else if (i_pre_sel[0]) begin
      pre_lim = EBPWM_PRE4_LIM;
    end else begin
      pre_lim = EBPWM_PRE1_LIM;
    end
  end

  assign step = i_run && (pre_cnt_q >= pre_lim);
  assign tick = step && (phase_q == EBPWM_QPHASE_LAST);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt_q <= 4'h0;
      phase_q <= 2'h0;
      tmr_q <= 8'h00;
      wrap_q <= 1'b0;
    end else begin
      wrap_q <= 1'b0;
      if (i_run) begin
        pre_cnt_q <= step ? 4'h0 : pre_cnt_q + 4'h1;
      end
      if (step) begin
        phase_q <= phase_q + 2'h1;
      end
      // Lowered period still wraps instead of running to 255
      if (tick && (tmr_q >= i_period)) begin
        tmr_q <= 8'h00;
        wrap_q <= 1'b1;
      end else if (tick) begin
        tmr_q <= tmr_q + 8'h01;
      end
    end
  end

  assign o_timer = tmr_q;
  assign o_fine = {tmr_q, phase_q};
  assign o_wrap = wrap_q;

endmodule

/* File: rtl/ebpwm_deadband.sv */
// Purpose: Rising-edge delay of one half-bridge drive signal
// Assumes: i_in is active-high logic level, before polarity
// Notes:   Falling edges pass after one cycle; a short pulse never shows

`timescale 1ns/100ps

module ebpwm_deadband
  import ebpwm_pkg::*;
#(
  parameter int W = 7,
  parameter int MULT = EBPWM_DB_CYC_PER_COUNT
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_in,
  input wire logic [W-1:0] i_count,
  output logic o_out
);

  logic [W+2:0] target;
  logic [W+2:0] cnt_q;
  logic out_q;

  assign target = (W+3)'(32'(i_count) * MULT);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (!i_in) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (cnt_q >= target) begin
      // Compare with >= so a count lowered mid-delay cannot stall
      out_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + (W+3)'(1);
    end
  end

  assign o_out = out_q;

endmodule

/* File: rtl/ebpwm_top.sv */
// Purpose: Enhanced PWM output stage driving up to four bridge pins
// Assumes: Oscillator clock on i_clk_sys; registers on a plain 8-bit port
// Notes:   Pin enables low mean the pin is released to its port function
//
// Overview of operation
// - The two-bit output config picks single, half-bridge, forward or reverse.
// - A ten-bit duty compare makes one waveform that can reach four pins.
// - Pin active levels are set by the mode-select field of the control register.
// - After enabling, no waveform appears until the next period starts.
// - Half-bridge puts the waveform on A and its complement on B.
// - Half-bridge delays each output's active edge by the dead-band count.
// - A dead-band count longer than the active time keeps that output inactive.
// - Dead-band delay is the count times four oscillator periods.
// - Half-bridge uses only A and B and leaves C and D undriven.
// - Pins unused by the current configuration are released.
// - Single mode places the waveform on each pin whose steering bit is set.
// - Forward holds A active and modulates D; reverse holds C and modulates B.
// - Mode codes 1100 to 1111 set pair A/C low-active by bit 1, B/D by bit 0.
// - A bridge direction change blanks modulation, swaps sides, resumes next period.
//
// The implementer's own choices: the placing of the registers and the strobed register port.

`timescale 1ns/100ps

module ebpwm_top
  import ebpwm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [EBPWM_AW-1:0] i_addr,
  input wire logic [EBPWM_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [EBPWM_DW-1:0] o_rdata,
  output logic o_pwm_out_a,
  output logic o_pwm_out_b,
  output logic o_pwm_out_c,
  output logic o_pwm_out_d,
  output logic o_pwm_oe_a,
  output logic o_pwm_oe_b,
  output logic o_pwm_oe_c,
  output logic o_pwm_oe_d
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] unit_control_reg_q;
  logic [7:0] deadband_control_reg_q;
  logic [7:0] period_compare_reg_q;
  logic [7:0] duty_high_byte_q;
  logic [7:0] timer_ctrl_q;
  logic [3:0] steer_q;
  logic [7:0] rdata_q;

  ebpwm_cfg_e output_config_field;
  logic [3:0] unit_mode_select;
  logic [6:0] deadband_count;
  logic [9:0] duty_req;
  logic [9:0] duty_act_q;
  logic [9:0] duty_use;
  logic pwm_en;
  logic timer_on;
  logic pol_ac;
  logic pol_bd;
  logic [3:0] pol;

  logic [7:0] pwm_time_base;
  logic [9:0] fine;
  logic period_start;

  ebpwm_state_e state_q;
  logic run_use;
  logic pwm_raw_q;
  logic dir_req;
  logic dir_q;
  logic hold_q;
  logic full_sel;
  logic half_sel;
  logic db_a_out;
  logic db_b_out;

  logic [3:0] act_d;
  logic [3:0] oe_d;
  logic [3:0] pin_q;
  logic [3:0] oe_q;

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // config decode
  assign output_config_field =
    ebpwm_cfg_e'(unit_control_reg_q[EBPWM_CFG_MSB:EBPWM_CFG_LSB]);
  assign unit_mode_select = unit_control_reg_q[EBPWM_MSEL_MSB:EBPWM_MSEL_LSB];
  assign deadband_count = deadband_control_reg_q[6:0];
  assign duty_req = {duty_high_byte_q, unit_control_reg_q[EBPWM_DLO_MSB:EBPWM_DLO_LSB]};
  assign pwm_en = (unit_mode_select[3:2] == EBPWM_MSEL_PWM);
  assign timer_on = timer_ctrl_q[EBPWM_TON_BIT];
  assign pol_ac = unit_mode_select[EBPWM_POL_AC_BIT];
  assign pol_bd = unit_mode_select[EBPWM_POL_BD_BIT];
  assign pol = {pol_bd, pol_ac, pol_bd, pol_ac};
  assign full_sel = output_config_field[0];
  assign half_sel = (output_config_field == EBPWM_CFG_HALF);
  assign dir_req = output_config_field[1];

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      unit_control_reg_q <= EBPWM_RST_CTRL;
      deadband_control_reg_q <= EBPWM_RST_DBAND;
      period_compare_reg_q <= EBPWM_RST_PERIOD;
      duty_high_byte_q <= EBPWM_RST_DUTY;
      timer_ctrl_q <= EBPWM_RST_TCTRL;
      steer_q <= EBPWM_RST_STEER;
    end else if (i_wr) begin
      if (i_addr == EBPWM_OFS_CTRL) begin
        unit_control_reg_q <= i_wdata;
      end else if (i_addr == EBPWM_OFS_DBAND) begin
        deadband_control_reg_q <= {1'b0, i_wdata[6:0]};
      end else if (i_addr == EBPWM_OFS_PERIOD) begin
        period_compare_reg_q <= i_wdata;
      end else if (i_addr == EBPWM_OFS_DUTY) begin
        duty_high_byte_q <= i_wdata;
      end else if (i_addr == EBPWM_OFS_TCTRL) begin
        timer_ctrl_q <= {5'h00, i_wdata[2:0]};
      end else if (i_addr == EBPWM_OFS_STEER) begin
        steer_q <= i_wdata[3:0];
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 8'h00;
    end else if (!i_rd) begin
      rdata_q <= 8'h00;
    end else if (i_addr == EBPWM_OFS_CTRL) begin
      rdata_q <= unit_control_reg_q;
    end else if (i_addr == EBPWM_OFS_DBAND) begin
      rdata_q <= deadband_control_reg_q;
    end else if (i_addr == EBPWM_OFS_PERIOD) begin
      rdata_q <= period_compare_reg_q;
    end else if (i_addr == EBPWM_OFS_DUTY) begin
      rdata_q <= duty_high_byte_q;
    end else if (i_addr == EBPWM_OFS_TCTRL) begin
      rdata_q <= timer_ctrl_q;
    end else if (i_addr == EBPWM_OFS_STEER) begin
      rdata_q <= {4'h0, steer_q};
    end else if (i_addr == EBPWM_OFS_STATUS) begin
      rdata_q <= {1'b0, hold_q, dir_q, (state_q == EBPWM_ST_RUN), pin_q};
    end else begin
      rdata_q <= pwm_time_base;
    end
  end

  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  // period and fine count
  ebpwm_timebase u_timebase (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_run(timer_on),
    .i_pre_sel(timer_ctrl_q[1:0]),
    .i_period(period_compare_reg_q),
    .o_timer(pwm_time_base),
    .o_fine(fine),
    .o_wrap(period_start)
  );

  // Duty is double-buffered so a mid-period write cannot glitch the pulse
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      duty_act_q <= 10'h000;
    end else if (period_start) begin
      duty_act_q <= duty_req;
    end
  end

  // ----------------------------------------------------------------
  // Start-up sequencing
  // ----------------------------------------------------------------
  // wait for a period start
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q <= EBPWM_ST_OFF;
    end else if (!pwm_en || !timer_on) begin
      state_q <= EBPWM_ST_OFF;
    end else begin
      case (state_q)
        EBPWM_ST_OFF: begin
          state_q <= EBPWM_ST_ARMED;
        end
        EBPWM_ST_ARMED: begin
          if (period_start) begin
            state_q <= EBPWM_ST_RUN;
          end
        end
        EBPWM_ST_RUN: begin
          state_q <= EBPWM_ST_RUN;
        end
        default: begin
          state_q <= EBPWM_ST_OFF;
        end
      endcase
    end
  end

  assign run_use = pwm_en && timer_on &&
    ((state_q == EBPWM_ST_RUN) || ((state_q == EBPWM_ST_ARMED) && period_start));
  assign duty_use = period_start ? duty_req : duty_act_q;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pwm_raw_q <= 1'b0;
    end else begin
      pwm_raw_q <= run_use && (fine < duty_use);
    end
  end

  // ----------------------------------------------------------------
  // Bridge direction
  // ----------------------------------------------------------------
  // blank, swap, resume next period
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      dir_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (full_sel && (dir_req != dir_q)) begin
      dir_q <= dir_req;
      hold_q <= 1'b1;
    end else if (!full_sel) begin
      dir_q <= dir_req;
      hold_q <= 1'b0;
    end else if (period_start) begin
      hold_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Dead band
  // ----------------------------------------------------------------
  // delayed active edges
  ebpwm_deadband #(
    .W(7),
    .MULT(EBPWM_DB_CYC_PER_COUNT)
  ) u_db_a (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_in(half_sel && pwm_raw_q),
    .i_count(deadband_count),
    .o_out(db_a_out)
  );

  ebpwm_deadband #(
    .W(7),
    .MULT(EBPWM_DB_CYC_PER_COUNT)
  ) u_db_b (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_in(half_sel && (state_q == EBPWM_ST_RUN) && !pwm_raw_q),
    .i_count(deadband_count),
    .o_out(db_b_out)
  );

  // ----------------------------------------------------------------
  // Pin steering
  // ----------------------------------------------------------------
  always_comb begin
    act_d = 4'h0;
    oe_d = 4'h0;
    if (pwm_en) begin
      case (output_config_field)
        EBPWM_CFG_SINGLE: begin
          oe_d = steer_q;
          act_d = pwm_raw_q ? steer_q : 4'h0;
        end
        EBPWM_CFG_HALF: begin
          oe_d = 4'b0011;
          act_d = {2'b00, db_b_out, db_a_out};
        end
        default: begin
          oe_d = 4'b1111;
          if (!dir_q) begin
            act_d = {pwm_raw_q && !hold_q, 2'b00, 1'b1};
          end else begin
            act_d = {1'b0, 1'b1, pwm_raw_q && !hold_q, 1'b0};
          end
          act_d = act_d & {4{state_q == EBPWM_ST_RUN}};
        end
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
          pin_q[gi] <= 1'b0;
          oe_q[gi] <= 1'b0;
        end else begin
          pin_q[gi] <= act_d[gi] ^ pol[gi];
          oe_q[gi] <= oe_d[gi];
        end
      end
    end
  endgenerate

  assign o_pwm_out_a = pin_q[0];
  assign o_pwm_out_b = pin_q[1];
  assign o_pwm_out_c = pin_q[2];
  assign o_pwm_out_d = pin_q[3];
  assign o_pwm_oe_a = oe_q[0];
  assign o_pwm_oe_b = oe_q[1];
  assign o_pwm_oe_c = oe_q[2];
  assign o_pwm_oe_d = oe_q[3];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  sequence seq_dir_flip;
    full_sel && (dir_req != dir_q);
  endsequence

  sequence seq_swapped;
    hold_q && (dir_q == $past(dir_req));
  endsequence

  AST_DIR_SWAP: assert property (seq_dir_flip |=> seq_swapped)
    else $error("direction change did not swap and blank");

  AST_HOLD_END: assert property (hold_q && period_start && full_sel && (dir_req == dir_q)
    |=> !hold_q)
    else $error("modulation not resumed at period start");

  AST_START_WAIT: assert property ($rose(state_q == EBPWM_ST_RUN) |-> $past(period_start))
    else $error("waveform started outside a period start");

  AST_HALF_OE: assert property (pwm_en && half_sel |=> !o_pwm_oe_c && !o_pwm_oe_d
    && o_pwm_oe_a && o_pwm_oe_b)
    else $error("half-bridge pin enables wrong");

  AST_DB_DELAY: assert property (half_sel && $rose(pwm_raw_q) && (deadband_count != 7'h00)
    |=> !db_a_out [*4])
    else $error("dead band shorter than four cycles");

  AST_DB_ZERO: assert property (half_sel && pwm_raw_q && (deadband_count == 7'h00)
    |=> db_a_out)
    else $error("zero dead band delayed the edge");

  AST_FWD_PINS: assert property (pwm_en && (output_config_field == EBPWM_CFG_FWD) && !dir_q
    && (state_q == EBPWM_ST_RUN) |=> (o_pwm_out_a != pol_ac) && (o_pwm_out_b == pol_bd)
    && (o_pwm_out_c == pol_ac))
    else $error("forward bridge pins wrong");

  AST_IDLE_LEVEL: assert property (!pwm_en |=> (pin_q == $past(pol)) && (oe_q == 4'h0))
    else $error("idle pins not at inactive level");

  AST_STEER: assert property (pwm_en && (output_config_field == EBPWM_CFG_SINGLE)
    |=> oe_q == $past(steer_q))
    else $error("steering enables not applied");

  AST_DUTY_LOAD: assert property (period_start |=> duty_act_q == $past(duty_req))
    else $error("duty not loaded at period start");

endmodule

/* File: verif/ebpwm_switch_model.sv */
// Purpose: Behavioural power-switch driver stage on the four bridge pins
// Assumes: Board pull-downs hold a released pin low, so its switch stays off
// Notes:   Latches a flag when the A and B switches conduct together

`timescale 1ns/100ps

module ebpwm_switch_model (
  input wire logic i_clk_sys,
  input wire logic i_clr,
  input wire logic [3:0] i_out,
  input wire logic [3:0] i_oe,
  output logic [3:0] o_wire,
  output logic o_shoot
);
  // Released pin shows the pull-down, never the stale drive level
  assign o_wire = i_out & i_oe;

  initial o_shoot = 1'b0;

  // Shoot-through only matters for half-bridge runs; bench clears it first
  always @(posedge i_clk_sys) begin
    if (i_clr) begin
      o_shoot <= 1'b0;
    end else if (o_wire[0] && o_wire[1]) begin
      o_shoot <= 1'b1;
    end
  end
endmodule

/* File: verif/test_enhanced_bridge_pwm_output.sv */
// Purpose: Self-checking bench of the enhanced bridge PWM output stage
// Assumes: Prescale 1 unless set, period register 15 (64 cycles), duty 40 steps
// Notes:   Pin activity is counted over whole periods, so phase does not matter

`timescale 1ns/100ps

module test_enhanced_bridge_pwm_output;
  import ebpwm_pkg::*;

  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic clr = 1'b0;
  logic [7:0] o_rdata;
  wire [3:0] pout, poe, wire_lvl;
  logic shoot;
  int bad_count = 0;
  int compares = 0;
  int cnt [4];

  always #25 i_clk_sys = ~i_clk_sys;

  ebpwm_top DUT (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_pwm_out_a(pout[0]), .o_pwm_out_b(pout[1]), .o_pwm_out_c(pout[2]),
    .o_pwm_out_d(pout[3]), .o_pwm_oe_a(poe[0]), .o_pwm_oe_b(poe[1]),
    .o_pwm_oe_c(poe[2]), .o_pwm_oe_d(poe[3])
  );

  ebpwm_switch_model u_model (
    .i_clk_sys(i_clk_sys), .i_clr(clr), .i_out(pout), .i_oe(poe),
    .o_wire(wire_lvl), .o_shoot(shoot)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(posedge i_clk_sys);
    chk({8'h00, o_rdata}, {8'h00, exp});
  endtask

  task automatic count_span(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge i_clk_sys);
      for (int k = 0; k < 4; k++) cnt[k] += int'(wire_lvl[k]);
    end
  endtask

  task automatic chk_counts(input int a, input int b, input int c, input int d);
    chk(16'(cnt[0]), 16'(a));
    chk(16'(cnt[1]), 16'(b));
    chk(16'(cnt[2]), 16'(c));
    chk(16'(cnt[3]), 16'(d));
  endtask

  task automatic wait_high(input int k);
    int n;
    n = 0;
    while (wire_lvl[k] !== 1'b1 && n < 300) begin
      @(posedge i_clk_sys);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [7:0] rst_v [6];
    rst_v = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h01};
    for (int a = 0; a < 6; a++) rd(3'(a), rst_v[a]);
    rd(EBPWM_OFS_TIMER, 8'h00);
    // Unimplemented bits read zero
    wr(EBPWM_OFS_DBAND, 8'hFF);
    rd(EBPWM_OFS_DBAND, 8'h7F);
    wr(EBPWM_OFS_TCTRL, 8'hF8);
    rd(EBPWM_OFS_TCTRL, 8'h00);
    wr(EBPWM_OFS_STEER, 8'hF5);
    rd(EBPWM_OFS_STEER, 8'h05);
    $display("test regs done");
  endtask

  task automatic t_single;
    int len;
    wr(EBPWM_OFS_PERIOD, 8'h0F);
    wr(EBPWM_OFS_DUTY, 8'h0A);
    wr(EBPWM_OFS_TCTRL, 8'h04);
    repeat (20) @(posedge i_clk_sys);
    // Enable mid-period: first pulse must be whole
    wr(EBPWM_OFS_CTRL, 8'h0C);
    wait_high(0);
    len = 0;
    while (wire_lvl[0] === 1'b1 && len < 100) begin
      @(posedge i_clk_sys);
      len++;
    end
    chk(16'(len), 16'd40);
    chk({12'h000, poe}, 16'h0005);
    count_span(64);
    chk_counts(40, 0, 40, 0);
    $display("test single done");
  endtask

  task automatic t_polarity;
    wr(EBPWM_OFS_STEER, 8'h03);
    for (int m = 12; m < 16; m++) begin
      wr(EBPWM_OFS_CTRL, {4'h0, 4'(m)});
      repeat (128) @(posedge i_clk_sys);
      count_span(64);
      chk(16'(cnt[0]), (m & 2) != 0 ? 16'd24 : 16'd40);
      chk(16'(cnt[1]), (m & 1) != 0 ? 16'd24 : 16'd40);
    end
    $display("test polarity done");
  endtask

  task automatic t_bridge;
    wr(EBPWM_OFS_CTRL, 8'h4C);
    repeat (128) @(posedge i_clk_sys);
    count_span(64);
    chk_counts(64, 0, 0, 40);
    chk({12'h000, poe}, 16'h000F);
    wait_high(3);
    wr(EBPWM_OFS_CTRL, 8'hCC);
    repeat (4) @(posedge i_clk_sys);
    // Modulated pins blank before the period ends
    chk({14'h0000, wire_lvl[3], wire_lvl[1]}, 16'h0000);
    // Blanking, reverse, running, only C active
    rd(EBPWM_OFS_STATUS, 8'h74);
    repeat (128) @(posedge i_clk_sys);
    count_span(64);
    chk_counts(0, 40, 64, 0);
    $display("test bridge done");
  endtask

  task automatic t_half;
    wr(EBPWM_OFS_DBAND, 8'h03);
    wr(EBPWM_OFS_CTRL, 8'h8C);
    repeat (128) @(posedge i_clk_sys);
    clr <= 1'b1;
    @(posedge i_clk_sys);
    clr <= 1'b0;
    count_span(64);
    // Delay of 3 counts is 12 cycles off each active edge
    chk_counts(28, 12, 0, 0);
    chk({12'h000, poe}, 16'h0003);
    chk({15'h0000, shoot}, 16'h0000);
    wr(EBPWM_OFS_DBAND, 8'h32);
    repeat (128) @(posedge i_clk_sys);
    count_span(64);
    chk_counts(0, 0, 0, 0);
    wr(EBPWM_OFS_DBAND, 8'h00);
    repeat (128) @(posedge i_clk_sys);
    count_span(64);
    // Zero dead band gives the exact complement
    chk_counts(40, 24, 0, 0);
    wr(EBPWM_OFS_TCTRL, 8'h05);
    repeat (512) @(posedge i_clk_sys);
    count_span(256);
    chk_counts(160, 96, 0, 0);
    wr(EBPWM_OFS_TCTRL, 8'h06);
    repeat (2048) @(posedge i_clk_sys);
    count_span(1024);
    chk_counts(640, 384, 0, 0);
    $display("test half done");
  endtask

  task automatic t_off;
    wr(EBPWM_OFS_CTRL, 8'h00);
    repeat (8) @(posedge i_clk_sys);
    chk({8'h00, pout, poe}, 16'h0000);
    $display("test off done");
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    t_regs();
    t_single();
    t_polarity();
    t_bridge();
    t_half();
    t_off();
    test_done();
  end

  // Tests need about 6000 cycles; a hang is cut well past that
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    bad_count++;
    test_done();
  end
endmodule
